//--- shared/bkc_pkg.sv
// constants for the backlash compensation stage
`default_nettype none
package bkc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_AMOUNT   = 8'h04;
    localparam logic [7:0] OFF_FILT_TC  = 8'h08;
    localparam logic [7:0] OFF_GEAR_NUM = 8'h0C;
    localparam logic [7:0] OFF_GEAR_DEN = 8'h10;
    localparam logic [7:0] OFF_MAX_SPD  = 8'h14;
    localparam logic [7:0] OFF_ENC_RES  = 8'h18;
    localparam logic [7:0] OFF_EXT_RES  = 8'h1C;
    localparam logic [7:0] OFF_LIMIT    = 8'h20;
    localparam logic [7:0] OFF_STATUS   = 8'h24;
    localparam logic [7:0] OFF_COMP_VAL = 8'h28;
    // field positions
    localparam int CTRL_DIR_BIT     = 0;
    localparam int CTRL_RESTART_BIT = 1;
    localparam int CTRL_FCLOSED_BIT = 2;
    // reset values
    localparam logic [31:0] RST_AMOUNT   = 32'h0000_0000;
    localparam logic [15:0] RST_FILT_TC  = 16'h0000;
    localparam logic [31:0] RST_GEAR     = 32'h0000_0001;
    localparam logic [15:0] RST_MAX_SPD  = 16'h0BB8;
    localparam logic [31:0] RST_ENC_RES  = 32'h0001_0000;
    // amount range, 0.1 reference unit
    localparam logic signed [31:0] AMOUNT_MAX = 32'sh0007_A120;
    localparam logic signed [31:0] AMOUNT_MIN = -32'sh0007_A120;
    // limit = den*spd*res / (num*60*400), in 0.1 unit (x10 of 0.00025)
    localparam logic [15:0] LIMIT_DIV = 16'h5DC0;
    // control cycle in units of 0.01 ms
    localparam logic [15:0] CYCLE_TS  = 16'h0019;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- design/bkc_backlash_comp.sv
// backlash compensation stage with AXI4-Lite register access
//
// Notes on behaviour
// - direction bit applied only at restart
// - motor reference is host reference plus filtered compensation pulses
// - compensation only in position control
// - signed amount +-500000, default zero, immediate
// - amount times gear rounded to nearest pulse
// - skip compensation when amount exceeds limit
// - fully-closed uses external pulses per revolution
// - computed limit readable in monitor register
// - first-order lag filter, zero constant bypasses
// - new time constant adopted only when idle
// - opposite-direction references get no compensation
// - servo off withholds compensation
// - overtravel behaves like servo off
// - reported feedback has active amount subtracted
`default_nettype none
module bkc_backlash_comp
    import bkc_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               ctrlTick,
    input  wire logic signed [31:0] posRef,
    input  wire logic               refMoving,
    input  wire logic               refReverse,
    input  wire logic               motorStopped,
    input  wire logic               servoOn,
    input  wire logic               posCtrlMode,
    input  wire logic               driveProhibit,
    input  wire logic signed [31:0] feedbackPos,
    input  wire logic signed [31:0] latchPos,
    output logic signed [31:0]      motorRef,
    output logic signed [31:0]      machineFeedbackPosition,
    output logic signed [31:0]      latchFeedbackPos
);
    logic               awHeld_q, wHeld_q, bvalid_q, rvalid_q;
    logic [7:0]         awAddr_q;
    logic [31:0]        wData_q, rdata_q;
    logic [3:0]         wStrb_q;
    logic [1:0]         bresp_q, rresp_q;
    logic               dirPend_q, dirActive_q, fullyClosed_q, restartPulse_q;
    logic signed [31:0] amount_q;
    logic [15:0]        tcPend_q, tcActive_q, maxSpd_q;
    logic [31:0]        gearNum_q, gearDen_q, encRes_q, extRes_q;
    logic [31:0]        limit_q;
    logic signed [31:0] pulses_q, filt_q, target;
    logic               engaged_q, withinLimit, gate;
    logic [31:0]        wrVal, curVal, rdMux;
    logic               wrErr, doWrite;
    logic [79:0]        limitProd;
    logic [79:0]        limitQuot;
    logic [19:0]        absAmount;
    logic [63:0]        roundNum, roundDen, roundQuot;
    logic signed [47:0] diff, step;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: address and data may arrive in either order
    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready  = !wHeld_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign doWrite       = awHeld_q && wHeld_q && !bvalid_q;

    always_comb begin
        curVal = 32'h0000_0000;
        if (awAddr_q == OFF_CTRL) begin
            curVal = {29'h0000_0000, fullyClosed_q, 1'b0, dirPend_q};
        end else if (awAddr_q == OFF_AMOUNT) begin
            curVal = amount_q;
        end else if (awAddr_q == OFF_FILT_TC) begin
            curVal = {16'h0000, tcPend_q};
        end else if (awAddr_q == OFF_GEAR_NUM) begin
            curVal = gearNum_q;
        end else if (awAddr_q == OFF_GEAR_DEN) begin
            curVal = gearDen_q;
        end else if (awAddr_q == OFF_MAX_SPD) begin
            curVal = {16'h0000, maxSpd_q};
        end else if (awAddr_q == OFF_ENC_RES) begin
            curVal = encRes_q;
        end else if (awAddr_q == OFF_EXT_RES) begin
            curVal = extRes_q;
        end
        for (int i = 0; i < 4; i++) begin
            wrVal[8*i +: 8] = wStrb_q[i] ? wData_q[8*i +: 8] : curVal[8*i +: 8];
        end
    end

    // out-of-range amount and zero gear terms are refused and the old value kept
    always_comb begin
        wrErr = 1'b0;
        if (awAddr_q == OFF_AMOUNT) begin
            wrErr = ($signed(wrVal) > AMOUNT_MAX) || ($signed(wrVal) < AMOUNT_MIN);
        end else if (awAddr_q == OFF_GEAR_NUM || awAddr_q == OFF_GEAR_DEN) begin
            wrErr = (wrVal == 32'h0000_0000);
        end else if (awAddr_q == OFF_MAX_SPD) begin
            wrErr = (wrVal[31:16] != 16'h0000);
        end else if (awAddr_q == OFF_FILT_TC) begin
            wrErr = (wrVal[31:16] != 16'h0000);
        end else if (awAddr_q > OFF_EXT_RES || awAddr_q[1:0] != 2'h0) begin
            wrErr = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bvalid_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            bresp_q  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wrErr ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        if (s_axi_araddr == OFF_CTRL) begin
            rdMux = {29'h0000_0000, fullyClosed_q, 1'b0, dirPend_q};
        end else if (s_axi_araddr == OFF_AMOUNT) begin
            rdMux = amount_q;
        end else if (s_axi_araddr == OFF_FILT_TC) begin
            rdMux = {tcActive_q, tcPend_q};
        end else if (s_axi_araddr == OFF_GEAR_NUM) begin
            rdMux = gearNum_q;
        end else if (s_axi_araddr == OFF_GEAR_DEN) begin
            rdMux = gearDen_q;
        end else if (s_axi_araddr == OFF_MAX_SPD) begin
            rdMux = {16'h0000, maxSpd_q};
        end else if (s_axi_araddr == OFF_ENC_RES) begin
            rdMux = encRes_q;
        end else if (s_axi_araddr == OFF_EXT_RES) begin
            rdMux = extRes_q;
        end else if (s_axi_araddr == OFF_LIMIT) begin
            rdMux = limit_q;
        end else if (s_axi_araddr == OFF_STATUS) begin
            rdMux = {28'h000_0000, dirActive_q, gate, withinLimit, engaged_q};
        end else if (s_axi_araddr == OFF_COMP_VAL) begin
            rdMux = filt_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rdMux;
            rresp_q  <= (s_axi_araddr > OFF_COMP_VAL || s_axi_araddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dirPend_q      <= 1'b0;
            fullyClosed_q  <= 1'b0;
            restartPulse_q <= 1'b0;
            amount_q       <= RST_AMOUNT;
            tcPend_q       <= RST_FILT_TC;
            gearNum_q      <= RST_GEAR;
            gearDen_q      <= RST_GEAR;
            maxSpd_q       <= RST_MAX_SPD;
            encRes_q       <= RST_ENC_RES;
            extRes_q       <= RST_ENC_RES;
        end else begin
            restartPulse_q <= 1'b0;
            if (doWrite && !wrErr) begin
                if (awAddr_q == OFF_CTRL) begin
                    dirPend_q      <= wrVal[CTRL_DIR_BIT];
                    fullyClosed_q  <= wrVal[CTRL_FCLOSED_BIT];
                    restartPulse_q <= wrVal[CTRL_RESTART_BIT];
                end else if (awAddr_q == OFF_AMOUNT) begin
                    amount_q <= wrVal;
                end else if (awAddr_q == OFF_FILT_TC) begin
                    tcPend_q <= wrVal[15:0];
                end else if (awAddr_q == OFF_GEAR_NUM) begin
                    gearNum_q <= wrVal;
                end else if (awAddr_q == OFF_GEAR_DEN) begin
                    gearDen_q <= wrVal;
                end else if (awAddr_q == OFF_MAX_SPD) begin
                    maxSpd_q <= wrVal[15:0];
                end else if (awAddr_q == OFF_ENC_RES) begin
                    encRes_q <= wrVal;
                end else if (awAddr_q == OFF_EXT_RES) begin
                    extRes_q <= wrVal;
                end
            end
        end
    end

    // direction only moves at a software restart, as a power cycle would
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dirActive_q <= 1'b0;
        end else if (restartPulse_q) begin
            dirActive_q <= dirPend_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // limit and pulse conversion
    assign limitProd = 80'(gearDen_q) * 80'(maxSpd_q) * 80'(fullyClosed_q ? extRes_q : encRes_q);
    assign limitQuot = limitProd / (80'(gearNum_q) * 80'(LIMIT_DIV));
    assign absAmount = amount_q[31] ? 20'(-amount_q) : amount_q[19:0];
    // half a pulse added before the divide rounds the magnitude to nearest
    assign roundNum  = 64'(absAmount) * 64'(gearNum_q) * 64'h2 + 64'(gearDen_q) * 64'hA;
    assign roundDen  = 64'(gearDen_q) * 64'h14;
    assign roundQuot = roundNum / roundDen;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            limit_q  <= 32'h0000_0000;
            pulses_q <= 32'sh0000_0000;
        end else begin
            limit_q  <= (limitQuot[79:32] != 48'h0) ? 32'hFFFF_FFFF : limitQuot[31:0];
            pulses_q <= amount_q[31] ? -$signed(roundQuot[31:0]) : $signed(roundQuot[31:0]);
        end
    end

    assign withinLimit = (32'(absAmount) <= limit_q);
    assign gate = servoOn && posCtrlMode && !driveProhibit;
    assign target = (gate && engaged_q && withinLimit) ? pulses_q : 32'sh0000_0000;

    // compensation holds after a move in the selected direction until a move the other way or the gate drops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            engaged_q <= 1'b0;
        end else if (!gate) begin
            engaged_q <= 1'b0;
        end else if (refMoving) begin
            engaged_q <= (refReverse == dirActive_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lag filter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tcActive_q <= RST_FILT_TC;
        end else if (!refMoving && motorStopped) begin
            tcActive_q <= tcPend_q;
        end
    end

    assign diff = 48'(target) - 48'(filt_q);
    assign step = (diff * $signed({32'h0, CYCLE_TS})) / $signed({31'h0, 17'(tcActive_q) + 17'(CYCLE_TS)});

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            filt_q <= 32'sh0000_0000;
        end else if (!gate) begin
            filt_q <= 32'sh0000_0000;
        end else if (ctrlTick) begin
            if (tcActive_q == 16'h0000) begin
                filt_q <= target;
            end else if (step != 48'sh0) begin
                filt_q <= filt_q + 32'(step);
            end else if (diff != 48'sh0) begin
                // the truncated step would stall short of the target
                filt_q <= filt_q + (diff[47] ? -32'sh1 : 32'sh1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // position outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            motorRef                <= 32'sh0000_0000;
            machineFeedbackPosition <= 32'sh0000_0000;
            latchFeedbackPos        <= 32'sh0000_0000;
        end else begin
            motorRef                <= posRef + filt_q;
            machineFeedbackPosition <= feedbackPos - filt_q;
            latchFeedbackPos        <= latchPos - filt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_dir_restart: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(dirActive_q) |-> $past(restartPulse_q))
        else $error("direction changed without restart");
    a_ref_sum: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 motorRef == $past(posRef) + $past(filt_q))
        else $error("motor reference is not reference plus compensation");
    a_mode_gate: assert property (@(posedge clk) disable iff (!rst_b)
        !posCtrlMode |=> filt_q == 32'sh0)
        else $error("compensation outside position control");
    a_amount_range: assert property (@(posedge clk) disable iff (!rst_b)
        amount_q <= AMOUNT_MAX && amount_q >= AMOUNT_MIN)
        else $error("amount out of range");
    a_limit_skip: assert property (@(posedge clk) disable iff (!rst_b)
        ctrlTick && !withinLimit && tcActive_q == 16'h0 |=> filt_q == 32'sh0)
        else $error("compensation applied above limit");
    a_filter_bypass: assert property (@(posedge clk) disable iff (!rst_b)
        ctrlTick && gate && tcActive_q == 16'h0 |=> filt_q == $past(target))
        else $error("zero time constant did not bypass");
    a_tc_hold: assert property (@(posedge clk) disable iff (!rst_b)
        refMoving || !motorStopped |=> $stable(tcActive_q))
        else $error("time constant changed during motion");
    a_opposite_dir: assert property (@(posedge clk) disable iff (!rst_b)
        refMoving && refReverse != dirActive_q |=> !engaged_q && target == 32'sh0)
        else $error("compensation on opposite reference");
    a_servo_off: assert property (@(posedge clk) disable iff (!rst_b)
        !servoOn |=> filt_q == 32'sh0 ##1 machineFeedbackPosition == $past(feedbackPos))
        else $error("compensation while servo off");
    a_overtravel: assert property (@(posedge clk) disable iff (!rst_b)
        driveProhibit [*2] |-> filt_q == 32'sh0 && target == 32'sh0)
        else $error("compensation during overtravel");
    a_feedback_sub: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 latchFeedbackPos == $past(latchPos) - $past(filt_q))
        else $error("latched feedback not compensated");
    a_tick_only: assert property (@(posedge clk) disable iff (!rst_b)
        gate && !ctrlTick |=> $stable(filt_q))
        else $error("filter moved without control tick");
endmodule
`default_nettype wire

//--- sim/bkc_host_model.sv
// host controller model issuing position references
`default_nettype none
module bkc_host_model (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          goMove,
    input  wire logic          goReverse,
    input  wire logic          slow,
    output logic signed [31:0] posRef,
    output logic               refMoving,
    output logic               refReverse,
    output logic               motorStopped
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic signed [31:0] STEP = 32'sh25;
    logic phase;
    // a slow host issues a reference only every other cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            posRef <= '0;
            refMoving <= '0;
            refReverse <= '0;
            motorStopped <= '1;
            phase <= '0;
        end else begin
            phase <= ~phase;
            refMoving <= goMove && (!slow || phase);
            refReverse <= goReverse;
            motorStopped <= !goMove && !refMoving;
            if (goMove && (!slow || phase))
                posRef <= goReverse ? posRef - STEP : posRef + STEP;
        end
    end
endmodule
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the backlash compensation stage
`default_nettype none
module tb;
    import bkc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] NUM = 32'h4;
    localparam logic [31:0] SPD = 32'h1770;
    localparam logic [31:0] RES = 32'h0010_0000;
    localparam logic [31:0] EXT = 32'h0001_F400;
    // 60 s per minute over the 0.00025 factor, in 0.1 reference units
    localparam longint      LIM = longint'(SPD) * RES / (NUM * 32'h5DC0);
    logic               clk = '0;
    logic               rst_b = '0;
    logic [7:0]         s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]        s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]         s_axi_wstrb = 4'hF;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic               s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic               ctrlTick = '0, servoOn = '1, posCtrlMode = '1, driveProhibit = '0;
    logic               goMove = '0, goReverse = '0, slow = '0, refMoving, refReverse, motorStopped;
    logic signed [31:0] posRef, motorRef, machineFeedbackPosition, latchFeedbackPos;
    logic signed [31:0] feedbackPos = '0, latchPos = '0, amt, pul;
    logic signed [31:0] corner [5] = '{32'sh0001_0000, 32'sh0001_0001, -32'sh0001_0000, 32'sh3, -32'sh7};
    int                 n_errors = 0, cmp_count = 0;

    bkc_backlash_comp DUT (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctrlTick, .posRef, .refMoving,
        .refReverse, .motorStopped, .servoOn, .posCtrlMode, .driveProhibit, .feedbackPos, .latchPos, .motorRef,
        .machineFeedbackPosition, .latchFeedbackPos);
    bkc_host_model host (.clk, .rst_b, .goMove, .goReverse, .slow, .posRef, .refMoving, .refReverse, .motorStopped);

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // entered just after a rising edge; each valid drops once its ready is seen, then one idle edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        s_axi_bready <= '1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= '0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= '0;
        end while (!s_axi_bvalid);
        s_axi_bready <= '0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= '1;
        s_axi_rready <= '1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= '0;
        end while (!s_axi_rvalid);
        s_axi_rready <= '0;
        chk(s_axi_rdata, ex);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge clk);
    endtask

    task automatic move(input logic rev);
        goReverse <= rev;
        goMove <= '1;
        repeat (5) @(posedge clk);
        goMove <= '0;
    endtask

    // one filter step, then outputs must carry exactly the expected offset
    task automatic settle(input logic signed [31:0] ex);
        feedbackPos <= $urandom;
        latchPos <= $urandom;
        repeat (3) @(posedge clk);
        ctrlTick <= '1;
        @(posedge clk);
        ctrlTick <= '0;
        repeat (3) @(posedge clk);
        #1;
        chk(motorRef, posRef + ex);
        chk(machineFeedbackPosition, feedbackPos - ex);
        chk(latchFeedbackPos, latchPos - ex);
        @(posedge clk);
    endtask

    function automatic logic signed [31:0] expPul(input logic signed [31:0] a);
        longint m;
        m = a < 0 ? -longint'(a) : longint'(a);
        if (m > LIM)
            return '0;
        m = (m * NUM + 5) / 10;
        return 32'(a < 0 ? -m : m);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        test_done();
    end

    initial begin
        void'($urandom(32'h2C7A));
        repeat (16) @(posedge clk);
        rst_b <= '1;
        @(posedge clk);
        rd(OFF_AMOUNT, 32'h0, RESP_OKAY);
        rd(OFF_GEAR_DEN, RST_GEAR, RESP_OKAY);
        rd(OFF_LIMIT, 32'h2000, RESP_OKAY);
        wr(OFF_GEAR_NUM, NUM, RESP_OKAY);
        wr(OFF_MAX_SPD, SPD, RESP_OKAY);
        wr(OFF_ENC_RES, RES, RESP_OKAY);
        wr(OFF_EXT_RES, EXT, RESP_OKAY);
        rd(OFF_LIMIT, 32'(LIM), RESP_OKAY);
        wr(OFF_CTRL, 32'h4, RESP_OKAY);
        rd(OFF_LIMIT, 32'(longint'(SPD) * EXT / (NUM * 32'h5DC0)), RESP_OKAY);
        wr(OFF_CTRL, 32'h0, RESP_OKAY);
        wr(OFF_AMOUNT, 32'h0007_A121, RESP_SLVERR);
        wr(OFF_AMOUNT, -32'sh0007_A120, RESP_OKAY);
        rd(OFF_AMOUNT, -32'sh0007_A120, RESP_OKAY);
        wr(OFF_LIMIT, 32'h0, RESP_SLVERR);
        wr(OFF_GEAR_DEN, 32'h0, RESP_SLVERR);
        rd(8'h2C, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 11; i++) begin
            amt = i < 5 ? corner[i] : 32'($urandom_range(32'h0002_0000)) - 32'sh0001_0000;
            slow <= i[0];
            wr(OFF_AMOUNT, amt, RESP_OKAY);
            move('0);
            settle(expPul(amt));
        end
        slow <= '0;
        pul = expPul(32'(LIM));
        wr(OFF_AMOUNT, 32'(LIM), RESP_OKAY);
        move('0);
        settle(pul);
        move('1);
        settle('0);
        rd(OFF_STATUS, 32'h6, RESP_OKAY);
        for (int g = 0; g < 3; g++) begin
            move('0);
            servoOn <= g != 0;
            posCtrlMode <= g != 1;
            driveProhibit <= g == 2;
            settle('0);
            servoOn <= '1;
            posCtrlMode <= '1;
            driveProhibit <= '0;
        end
        wr(OFF_CTRL, 32'h1, RESP_OKAY);
        move('0);
        settle(pul);
        wr(OFF_CTRL, 32'h3, RESP_OKAY);
        move('0);
        settle('0);
        move('1);
        settle(pul);
        wr(OFF_CTRL, 32'h2, RESP_OKAY);
        wr(OFF_AMOUNT, 32'h0, RESP_OKAY);
        settle('0);
        s_axi_wstrb <= 4'h1;
        wr(OFF_FILT_TC, 32'hFFFF_0019, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(OFF_FILT_TC, 32'h0019_0019, RESP_OKAY);
        wr(OFF_AMOUNT, 32'(LIM), RESP_OKAY);
        move('0);
        settle(pul * 25 / (25 + 25));
        rd(OFF_COMP_VAL, 32'(pul * 25 / (25 + 25)), RESP_OKAY);
        goMove <= '1;
        @(posedge clk);
        wr(OFF_FILT_TC, 32'h64, RESP_OKAY);
        rd(OFF_FILT_TC, 32'h0019_0064, RESP_OKAY);
        goMove <= '0;
        repeat (4) @(posedge clk);
        rd(OFF_FILT_TC, 32'h0064_0064, RESP_OKAY);
        test_done();
    end
endmodule
`default_nettype wire
